// ### core/oag_core.v
`timescale 1ns/1ns
`include "oag_regs.vh"
module oag_core (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire        op_valid,
  input  wire [2:0]  op_src_mode,
  input  wire [2:0]  op_dst_mode,
  input  wire [3:0]  op_src_ptr,
  input  wire [3:0]  op_dst_ptr,
  input  wire [3:0]  op_ofs_reg,
  input  wire [3:0]  op_base_reg,
  input  wire [15:0] op_lit,
  input  wire [2:0]  op_lit_sel,
  input  wire [4:0]  op_step,
  input  wire        op_is_move,
  input  wire        op_dst_default_working_register,
  input  wire        op_table,
  input  wire        op_table_hi,
  input  wire        op_table_wr,
  input  wire        op_byte,
  input  wire        exec_in_boot,
  input  wire        exec_in_secure,
  input  wire [23:0] pmem_rdata,
  input  wire        res_we,
  input  wire [3:0]  res_idx,
  input  wire [15:0] res_data,
  input  wire        res_pair,
  input  wire [15:0] res_data_hi,
  output reg  [15:0] reg_rdata,
  output reg  [15:0] base_val_q,
  output reg  [15:0] src_val_q,
  output reg  [15:0] src_ea_q,
  output reg  [15:0] dst_ea_q,
  output reg         dmem_rd_q,
  output reg         dmem_wr_q,
  output reg         dst_default_working_register_q,
  output reg  [23:0] pmem_addr_q,
  output reg         pmem_rd_q,
  output reg         pmem_wr_q,
  output reg         pmem_cfg_q,
  output reg  [15:0] pdata_q,
  output reg         pdata_valid_q,
  output reg         busy_q,
  output reg         prot_fault_q
);

////////////////////////////////////////////////////////////////////////
// State codes
localparam ST_IDLE = 2'h0;  // Ready for a new operand
localparam ST_VIS  = 2'h1;  // Extra visibility cycle
localparam ST_DATA = 2'h2;  // Program data returns

////////////////////////////////////////////////////////////////////////
// Storage
reg  [15:0] default_working_register_q [0:15];   // Working registers
reg  [7:0]  tblpg_q;         // Table page register
reg  [7:0]  vispg_q;         // Visibility page register
reg  [15:0] corectl_q;       // Core control register
reg  [1:0]  prot_q;          // Segment protection enables
reg  [1:0]  state_q;         // Sequencer state
reg         kind_hi_q;       // Pending read is upper word
reg         kind_byte_q;     // Pending read is byte wide
reg         kind_vis_q;      // Pending read is visibility
reg         bsel_q;          // Byte select address bit
reg         fault_seen_q;    // Sticky protection fault
reg  [15:0] src_ea_d;        // Next source address
reg  [15:0] dst_ea_d;        // Next destination address
reg  [15:0] src_ptr_d;       // Source pointer after modify
reg  [15:0] dst_ptr_d;       // Destination pointer after modify
reg         src_mem;         // Source touches memory
reg         dst_mem;         // Destination touches memory
reg         vis_rd;          // Source read through window
reg         vis_wr;          // Destination in window
reg         prot_hit;        // Access to guarded segment
integer     i;

wire        take = ce & op_valid & (state_q == ST_IDLE) & ~busy_q;
wire [15:0] step = {{11{op_step[4]}}, op_step};
wire [15:0] ofs  = default_working_register_q[op_ofs_reg];  // Shared offset

////////////////////////////////////////////////////////////////////////
// Literal extraction by width
function [15:0] lit_ext;
  input [2:0]  sel;
  input [15:0] lit;
  begin
    case (sel)
      `OAG_L5:   lit_ext = {11'h000, lit[4:0]};
      `OAG_L10:  lit_ext = {6'h00, lit[9:0]};
      `OAG_L14:  lit_ext = {2'h0, lit[13:0]};
      `OAG_L16S: lit_ext = lit;
      `OAG_L8:   lit_ext = {8'h00, lit[7:0]};
      default:   lit_ext = lit;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Effective address for one operand
function [15:0] ea_of;
  input [2:0]  mode;
  input [15:0] ptr;
  input [15:0] offs;
  input [15:0] lit;
  input [15:0] raw;            // Unsized instruction field for file addresses
  input [15:0] stp;
  input        mv;
  begin
    case (mode)
      `OAG_M_FILE: ea_of = mv ? raw : (raw & `OAG_NEAR_MASK);
      `OAG_M_IND:  ea_of = ptr;
      `OAG_M_POST: ea_of = ptr;
      `OAG_M_PRE:  ea_of = ptr + stp;
      `OAG_M_IDX:  ea_of = ptr + offs;
      `OAG_M_LOFS: ea_of = ptr + lit;
      default:     ea_of = 16'h0000;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Pointer value after modify
function [15:0] ptr_next;
  input [2:0]  mode;
  input [15:0] ptr;
  input [15:0] stp;
  begin
    if ((mode == `OAG_M_POST) || (mode == `OAG_M_PRE)) begin
      ptr_next = ptr + stp;
    end else begin
      ptr_next = ptr;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Memory-operand test
function is_mem;
  input [2:0] mode;
  begin
    is_mem = (mode != `OAG_M_REG) && (mode != `OAG_M_LIT);
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Guarded segment test for one address
function seg_block;
  input [15:0] a;
  input [1:0]  pe;
  input        in_boot;
  input        in_sec;
  begin
    seg_block = (pe[`OAG_PROT_BOOT] & ~in_boot &
                 (a >= `OAG_BOOT_RAM_LO) & (a <= `OAG_BOOT_RAM_HI)) |
                (pe[`OAG_PROT_SEC] & ~in_sec &
                 (a >= `OAG_SEC_RAM_LO) & (a <= `OAG_SEC_RAM_HI));
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Address computation for both operands
always @* begin
  // Literal offsets, file addresses all come from op_lit
  // File mode takes the raw field, so the literal width never cuts it
  src_ea_d  = ea_of(op_src_mode, default_working_register_q[op_src_ptr], ofs,
                    lit_ext(op_lit_sel, op_lit), op_lit,
                    step, op_is_move);
  dst_ea_d  = ea_of(op_dst_mode, default_working_register_q[op_dst_ptr], ofs,
                    lit_ext(op_lit_sel, op_lit), op_lit,
                    step, op_is_move);
  src_ptr_d = ptr_next(op_src_mode, default_working_register_q[op_src_ptr], step);
  dst_ptr_d = ptr_next(op_dst_mode, default_working_register_q[op_dst_ptr], step);
  src_mem   = is_mem(op_src_mode);
  dst_mem   = is_mem(op_dst_mode) & ~op_dst_default_working_register;
  // Window only on top bit with enable, not during table ops
  vis_rd    = src_mem & ~op_table & src_ea_d[15] &
              corectl_q[`OAG_CORECTL_VIS];
  vis_wr    = dst_mem & ~op_table & dst_ea_d[15] &
              corectl_q[`OAG_CORECTL_VIS];
  prot_hit  = (src_mem & seg_block(src_ea_d, prot_q, exec_in_boot, exec_in_secure)) |
              (dst_mem & seg_block(dst_ea_d, prot_q, exec_in_boot, exec_in_secure));
end

////////////////////////////////////////////////////////////////////////
// Working registers: pointer update, results, writeback
always @(posedge mclk) begin
  if (sys_rst) begin
    for (i = 0; i < 16; i = i + 1) begin
      default_working_register_q[i] <= 16'h0000;
    end
  end else if (ce) begin
    if (take && !prot_hit) begin
      default_working_register_q[op_src_ptr] <= src_ptr_d;
      default_working_register_q[op_dst_ptr] <= dst_ptr_d;                // Destination wins on same pointer
    end
    if (res_we) begin
      if (res_pair) begin
        default_working_register_q[res_idx]        <= res_data;
        default_working_register_q[res_idx + 4'h1] <= res_data_hi;
      end else if (op_dst_default_working_register) begin
        // Result index is ignored while the default register is selected
        default_working_register_q[0] <= res_data;
      end else begin
        default_working_register_q[res_idx] <= res_data;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Control registers and register reads
always @(posedge mclk) begin
  if (sys_rst) begin
    tblpg_q   <= `OAG_RST_PAGE;
    vispg_q   <= `OAG_RST_PAGE;
    corectl_q <= `OAG_RST_CTL;
    prot_q    <= `OAG_RST_PROT;
    reg_rdata <= 16'h0000;
  end else if (ce) begin
    if (reg_wr) begin
      if (reg_addr == `OAG_ADDR_TBLPG) begin
        tblpg_q <= reg_wdata[7:0];
      end else if (reg_addr == `OAG_ADDR_VISPG) begin
        vispg_q <= reg_wdata[7:0];
      end else if (reg_addr == `OAG_ADDR_CORECTL) begin
        corectl_q <= reg_wdata;
      end else if (reg_addr == `OAG_ADDR_PROT) begin
        prot_q <= reg_wdata[1:0];
      end
    end
    // Read data stands one cycle after the strobe
    if (reg_rd) begin
      if (reg_addr == `OAG_ADDR_TBLPG) begin
        reg_rdata <= {8'h00, tblpg_q};
      end else if (reg_addr == `OAG_ADDR_VISPG) begin
        reg_rdata <= {8'h00, vispg_q};
      end else if (reg_addr == `OAG_ADDR_CORECTL) begin
        reg_rdata <= corectl_q;
      end else if (reg_addr == `OAG_ADDR_PROT) begin
        reg_rdata <= {14'h0000, prot_q};
      end else if (reg_addr == `OAG_ADDR_STATUS) begin
        reg_rdata <= {13'h0000, fault_seen_q, state_q};
      end else if (reg_addr == `OAG_ADDR_LASTEA) begin
        reg_rdata <= src_ea_q;
      end else begin
        reg_rdata <= 16'h0000;                        // Unmapped reads zero
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Operand issue and program-space sequencer
always @(posedge mclk) begin
  if (sys_rst) begin
    state_q       <= ST_IDLE;
    base_val_q    <= 16'h0000;
    src_val_q     <= 16'h0000;
    src_ea_q      <= 16'h0000;
    dst_ea_q      <= 16'h0000;
    dmem_rd_q     <= 1'b0;
    dmem_wr_q     <= 1'b0;
    dst_default_working_register_q    <= 1'b0;
    pmem_addr_q   <= 24'h000000;
    pmem_rd_q     <= 1'b0;
    pmem_wr_q     <= 1'b0;
    pmem_cfg_q    <= 1'b0;
    pdata_q       <= 16'h0000;
    pdata_valid_q <= 1'b0;
    busy_q        <= 1'b0;
    prot_fault_q  <= 1'b0;
    fault_seen_q  <= 1'b0;
    kind_hi_q     <= 1'b0;
    kind_byte_q   <= 1'b0;
    kind_vis_q    <= 1'b0;
    bsel_q        <= 1'b0;
  end else if (ce) begin
    // Strobes default low
    dmem_rd_q     <= 1'b0;
    dmem_wr_q     <= 1'b0;
    pmem_rd_q     <= 1'b0;
    pmem_wr_q     <= 1'b0;
    pdata_valid_q <= 1'b0;
    prot_fault_q  <= 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          base_val_q <= default_working_register_q[op_base_reg];
          // Register direct gives contents, literal gives value
          if (op_src_mode == `OAG_M_REG) begin
            src_val_q <= default_working_register_q[op_src_ptr];
          end else begin
            src_val_q <= lit_ext(op_lit_sel, op_lit);
          end
          src_ea_q   <= src_ea_d;
          dst_ea_q   <= dst_ea_d;
          dst_default_working_register_q <= op_dst_default_working_register;
          if (prot_hit) begin
            prot_fault_q <= 1'b1;
            fault_seen_q <= 1'b1;
          end else if (op_table) begin
            // Page on top of address, page MSB picks space
            pmem_addr_q <= {tblpg_q, src_ea_d};
            pmem_cfg_q  <= tblpg_q[7];
            pmem_rd_q   <= ~op_table_wr;
            pmem_wr_q   <= op_table_wr;
            kind_hi_q   <= op_table_hi;
            kind_byte_q <= op_byte;
            kind_vis_q  <= 1'b0;
            bsel_q      <= src_ea_d[0];
            if (!op_table_wr) begin
              state_q <= ST_DATA;
              busy_q  <= 1'b1;
            end
          end else if (vis_rd) begin
            // Zero top bit keeps window in user space
            pmem_addr_q <= {1'b0, vispg_q, src_ea_d[14:0]};
            pmem_cfg_q  <= 1'b0;
            pmem_rd_q   <= 1'b1;
            kind_hi_q   <= 1'b0;
            kind_byte_q <= op_byte;
            kind_vis_q  <= 1'b1;
            bsel_q      <= src_ea_d[0];
            state_q     <= ST_VIS;
            busy_q      <= 1'b1;
          end else begin
            dmem_rd_q <= src_mem;
            dmem_wr_q <= dst_mem & ~vis_wr;           // Window writes dropped
          end
        end
      end
      ST_VIS: begin
        // Second fetch cycle of a window read
        state_q <= ST_DATA;
      end
      ST_DATA: begin
        // Shape returned program data
        if (kind_vis_q) begin
          pdata_q <= pmem_rdata[15:0];
        end else if (kind_hi_q) begin
          if (kind_byte_q) begin
            pdata_q <= bsel_q ? 16'h0000 : {8'h00, pmem_rdata[23:16]};
          end else begin
            pdata_q <= {8'h00, pmem_rdata[23:16]};
          end
        end else if (kind_byte_q) begin
          pdata_q <= bsel_q ? {8'h00, pmem_rdata[15:8]}
                            : {8'h00, pmem_rdata[7:0]};
        end else begin
          pdata_q <= pmem_rdata[15:0];
        end
        pdata_valid_q <= 1'b1;
        busy_q        <= 1'b0;
        state_q       <= ST_IDLE;
      end
      default: begin
        state_q <= ST_IDLE;
        busy_q  <= 1'b0;
      end
    endcase
  end
end

endmodule

// ### core/oag_regs.vh
`ifndef OAG_REGS_VH
`define OAG_REGS_VH
// Register indices on the plain register port
`define OAG_ADDR_TBLPG   4'h0
`define OAG_ADDR_VISPG   4'h1
`define OAG_ADDR_CORECTL 4'h2
`define OAG_ADDR_PROT    4'h3
`define OAG_ADDR_STATUS  4'h4
`define OAG_ADDR_LASTEA  4'h5
// Field positions
`define OAG_CORECTL_VIS  2
`define OAG_PROT_BOOT    0
`define OAG_PROT_SEC     1
// Reset values
`define OAG_RST_PAGE     8'h00
`define OAG_RST_CTL      16'h0000
`define OAG_RST_PROT     2'h0
// Boot and secure RAM segment bounds (byte addresses)
`define OAG_BOOT_RAM_LO  16'h0800
`define OAG_BOOT_RAM_HI  16'h08FF
`define OAG_SEC_RAM_LO   16'h0900
`define OAG_SEC_RAM_HI   16'h09FF
// Near data mask for file addresses
`define OAG_NEAR_MASK    16'h1FFF
// Addressing modes
`define OAG_M_FILE   3'h0
`define OAG_M_REG    3'h1
`define OAG_M_IND    3'h2
`define OAG_M_POST   3'h3
`define OAG_M_PRE    3'h4
`define OAG_M_IDX    3'h5
`define OAG_M_LOFS   3'h6
`define OAG_M_LIT    3'h7
// Literal width selects
`define OAG_L5       3'h0
`define OAG_L10      3'h1
`define OAG_L14      3'h2
`define OAG_L16S     3'h3
`define OAG_L8       3'h4
`define OAG_L16      3'h5
`endif

// ### sim/oag_chk_assertions.sv
`timescale 1ns/1ns
`include "oag_regs.vh"
module oag_chk (
  input wire        mclk,
  input wire        sys_rst,
  input wire        ce,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        op_valid,
  input wire [2:0]  op_src_mode,
  input wire [15:0] op_lit,
  input wire [2:0]  op_lit_sel,
  input wire        op_is_move,
  input wire        op_table,
  input wire        op_table_hi,
  input wire        op_byte,
  input wire        exec_in_boot,
  input wire        exec_in_secure,
  input wire [23:0] pmem_rdata,
  input wire [15:0] src_val_q,
  input wire [15:0] src_ea_q,
  input wire        dmem_rd_q,
  input wire        dmem_wr_q,
  input wire [23:0] pmem_addr_q,
  input wire        pmem_rd_q,
  input wire        pmem_cfg_q,
  input wire [15:0] pdata_q,
  input wire        pdata_valid_q,
  input wire        busy_q,
  input wire        prot_fault_q
);
  ////////////////////////////////////////
  reg  [7:0]  tpg_q;  // Shadow of table page
  reg  [7:0]  vpg_q;  // Shadow of visibility page
  reg         vis_q;  // Shadow of visibility enable
  reg  [1:0]  prot_q; // Shadow of protection enables
  reg         tbl_q;  // Last taken op was a table access
  reg         hi_q;   // Last taken op read the upper word
  reg         byt_q;  // Last taken op was byte mode
  reg  [23:0] prd_q;  // Program word of the previous cycle
  wire        take = ce && op_valid && !busy_q;
  // Follow register writes and the kind of each accepted operation
  always @(posedge mclk) begin
    prd_q <= pmem_rdata;
    if (sys_rst) begin
      {tpg_q, vpg_q, vis_q, prot_q, tbl_q, hi_q, byt_q} <= 22'h000000;
    end else if (ce) begin
      if (reg_wr && reg_addr == `OAG_ADDR_TBLPG) tpg_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `OAG_ADDR_VISPG) vpg_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `OAG_ADDR_CORECTL) vis_q <= reg_wdata[`OAG_CORECTL_VIS];
      if (reg_wr && reg_addr == `OAG_ADDR_PROT) prot_q <= reg_wdata[1:0];
      if (take) begin
        tbl_q <= op_table;
        hi_q <= op_table_hi;
        byt_q <= op_byte;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Start of a remapped or a table program fetch
  sequence s_vis_fetch;
    pmem_rd_q && $rose(busy_q) && !tbl_q;
  endsequence
  sequence s_tbl_fetch;
    pmem_rd_q && $rose(busy_q) && tbl_q;
  endsequence
  a_file_near: assert property (take && op_src_mode == `OAG_M_FILE |=>
    src_ea_q == ($past(op_lit) & ($past(op_is_move) ? 16'hFFFF : `OAG_NEAR_MASK)))
    else $error("file address width wrong");
  a_lit_five: assert property (take && op_src_mode == `OAG_M_LIT &&
    op_lit_sel == `OAG_L5 |=>
    src_val_q == ($past(op_lit) & 16'h001F)) else $error("short literal wrong");
  a_lit_count: assert property (take && op_src_mode == `OAG_M_LIT &&
    op_lit_sel == `OAG_L14 |=>
    src_val_q == ($past(op_lit) & 16'h3FFF)) else $error("count literal wrong");
  a_tbl_addr: assert property (s_tbl_fetch |-> pmem_addr_q == {tpg_q, src_ea_q})
    else $error("table address wrong");
  a_space_sel: assert property (pmem_rd_q |-> pmem_cfg_q == pmem_addr_q[23])
    else $error("space select wrong");
  a_vis_addr: assert property (s_vis_fetch |-> src_ea_q[15] && vis_q &&
    pmem_addr_q == {1'b0, vpg_q, src_ea_q[14:0]}) else $error("remap address wrong");
  a_vis_extra: assert property (s_vis_fetch |=> !pdata_valid_q && busy_q ##1
    pdata_valid_q && !busy_q) else $error("remap timing wrong");
  a_tbl_time: assert property (s_tbl_fetch |=> pdata_valid_q && !busy_q)
    else $error("table timing wrong");
  a_low_word: assert property (pdata_valid_q && !hi_q && !byt_q |->
    pdata_q == prd_q[15:0]) else $error("low word wrong");
  a_hi_phantom: assert property (pdata_valid_q && tbl_q && hi_q && !byt_q |->
    pdata_q == {8'h00, prd_q[23:16]}) else $error("upper word wrong");
  a_byte_pick: assert property (pdata_valid_q && tbl_q && !hi_q && byt_q |->
    pdata_q == {8'h00, src_ea_q[0] ? prd_q[15:8] : prd_q[7:0]}) else $error("byte pick wrong");
  a_fault_quiet: assert property (prot_fault_q |->
    !dmem_rd_q && !dmem_wr_q && !pmem_rd_q) else $error("strobe on fault");
  a_boot_guard: assert property (dmem_rd_q && prot_q[0] &&
    src_ea_q >= `OAG_BOOT_RAM_LO && src_ea_q <= `OAG_BOOT_RAM_HI |->
    $past(exec_in_boot)) else $error("boot ram open");
  a_sec_guard: assert property (dmem_rd_q && prot_q[1] && src_ea_q >= `OAG_SEC_RAM_LO &&
    src_ea_q <= `OAG_SEC_RAM_HI |-> $past(exec_in_secure)) else $error("secure ram open");
endmodule
bind oag_core oag_chk i_chk (.mclk, .sys_rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .op_valid,
  .op_src_mode, .op_lit, .op_lit_sel, .op_is_move, .op_table, .op_table_hi, .op_byte,
  .exec_in_boot, .exec_in_secure, .pmem_rdata, .src_val_q, .src_ea_q, .dmem_rd_q, .dmem_wr_q,
  .pmem_addr_q, .pmem_rd_q, .pmem_cfg_q, .pdata_q, .pdata_valid_q, .busy_q, .prot_fault_q);

// ### sim/oag_pmem_model.sv
`timescale 1ns/1ns
module oag_pmem_model (
  input  wire [23:0] pmem_addr_q,
  input  wire        busy_q,
  output reg  [23:0] pmem_rdata
);
  ////////////////////////////////////////
  // Word stored at a program address, set by address bits 15:0 only, so the page byte does not change it
  function [23:0] word_at(input [23:0] a);
    word_at = {a[7:0] ^ 8'hA5, a[15:0] ^ 16'h5A3C};
  endfunction
  // Read-only array: word while a fetch is open, inverse once released
  always @* begin
    if (busy_q) pmem_rdata = word_at(pmem_addr_q);
    else pmem_rdata = ~word_at(pmem_addr_q);
  end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ns
`include "oag_regs.vh"
module tb_top;
  reg         mclk, sys_rst, ce, reg_wr, reg_rd, op_valid, op_is_move, op_dst_default_working_register, res_we;
  reg         op_table, op_table_hi, op_table_wr, op_byte, exec_in_boot, exec_in_secure, res_pair;
  reg  [3:0]  reg_addr, op_src_ptr, op_dst_ptr, op_ofs_reg, op_base_reg, res_idx;
  reg  [2:0]  op_src_mode, op_dst_mode, op_lit_sel;
  reg  [4:0]  op_step;
  reg  [15:0] reg_wdata, op_lit, res_data, res_data_hi;
  reg  [23:0] w;
  wire [23:0] pmem_rdata, pmem_addr_q;
  wire [15:0] reg_rdata, base_val_q, src_val_q, src_ea_q, dst_ea_q, pdata_q;
  wire        dmem_rd_q, dmem_wr_q, dst_default_working_register_q, pmem_rd_q, pmem_wr_q, pmem_cfg_q;
  wire        pdata_valid_q, busy_q, prot_fault_q;
  integer     miscompares, n_compared, n, i;
  // Literal masks for widths 5, 10, 14, 16 signed, 8, 16
  localparam [95:0] LIT_MASKS = {16'hFFFF, 16'h00FF, 16'hFFFF, 16'h3FFF, 16'h03FF, 16'h001F};
  ////////////////////////////////////////
  oag_core i_dut (.mclk, .sys_rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .op_valid,
    .op_src_mode, .op_dst_mode, .op_src_ptr, .op_dst_ptr, .op_ofs_reg, .op_base_reg, .op_lit,
    .op_lit_sel, .op_step, .op_is_move, .op_dst_default_working_register, .op_table, .op_table_hi, .op_table_wr,
    .op_byte, .exec_in_boot, .exec_in_secure, .pmem_rdata, .res_we, .res_idx, .res_data,
    .res_pair, .res_data_hi, .reg_rdata, .base_val_q, .src_val_q, .src_ea_q, .dst_ea_q,
    .dmem_rd_q, .dmem_wr_q, .dst_default_working_register_q, .pmem_addr_q, .pmem_rd_q, .pmem_wr_q, .pmem_cfg_q,
    .pdata_q, .pdata_valid_q, .busy_q, .prot_fault_q);
  oag_pmem_model i_pmem (.pmem_addr_q, .busy_q, .pmem_rdata);
  always #25 mclk = ~mclk;
  // Expected program word at an address
  function [23:0] word_at(input [23:0] a);
    word_at = {a[7:0] ^ 8'hA5, a[15:0] ^ 16'h5A3C};
  endfunction
  task chk(input string what, input [39:0] seen, input [39:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Register bus write and read with check
  task wr(input [3:0] a, input [15:0] d);
    @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk) reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [15:0] e);
    @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk) reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask
  // Load a working register through the result port; default-register select is lowered
  task setw(input [3:0] a, input [15:0] d);
    @(posedge mclk) {res_idx, res_data, res_we, op_dst_default_working_register} <= {a, d, 1'b1, 1'b0};
    @(posedge mclk) res_we <= 1'b0;
  endtask
  // One operand request; returns just after the take edge, while strobes stand
  task go;
    @(posedge mclk) op_valid <= 1'b1;
    @(posedge mclk) op_valid <= 1'b0;
    #1;
  endtask
  // Bounded wait for program data, n counts cycles after the take cycle
  task pd_wait;
    n = 1;
    while (pdata_valid_q !== 1'b1 && n < 9) begin
      @(posedge mclk) #1 n = n + 1;
    end
    if (n == 9) begin
      miscompares = miscompares + 1;
      stop_test;
    end
  endtask
  ////////////////////////////////////////
  task s_regs;
    for (i = 0; i < 6; i = i + 1) rd(i[3:0], 16'h0000);
    wr(4'hF, 16'hBEEF);
    rd(4'hF, 16'h0000);
  endtask
  task s_file;
    {op_src_mode, op_lit} <= {`OAG_M_FILE, 16'hFFFF};
    go;
    chk("near ea", src_ea_q, 16'h1FFF);
    chk("to default_working_register", {dst_default_working_register_q, dmem_wr_q}, 2'b10);
    @(posedge mclk) {res_idx, res_data, res_we} <= {4'h9, 16'h00A5, 1'b1};
    @(posedge mclk) res_we <= 1'b0;
    go;
    chk("wreg0", base_val_q, 16'h00A5);
    op_is_move <= 1'b1;
    go;
    chk("move ea", src_ea_q, 16'hFFFF);
  endtask
  task s_lits;
    op_src_mode <= `OAG_M_LIT;
    for (i = 0; i < 6; i = i + 1) begin
      op_lit_sel <= i[2:0];
      go;
      chk("literal", src_val_q, LIT_MASKS[16*i +: 16]);
    end
  endtask
  task s_ind;
    setw(4'h3, 16'h1234);
    setw(4'h4, 16'h0010);
    {op_src_mode, op_src_ptr, op_base_reg} <= {`OAG_M_IND, 4'h3, 4'h3};
    go;
    chk("ind ea", src_ea_q, 16'h1234);
    chk("base", {base_val_q, dmem_rd_q}, {16'h1234, 1'b1});
    {op_src_mode, op_step} <= {`OAG_M_POST, 5'h02};
    go;
    chk("post ea", src_ea_q, 16'h1234);
    {op_src_mode, op_step} <= {`OAG_M_PRE, 5'h1E};
    go;
    chk("pre ea", src_ea_q, 16'h1234);
    {op_src_mode, op_lit, op_lit_sel} <= {`OAG_M_LOFS, 16'h0006, `OAG_L16};
    go;
    chk("lofs ea", src_ea_q, 16'h123A);
  endtask
  task s_move;
    {op_src_mode, op_ofs_reg, op_dst_mode, op_dst_ptr} <= {`OAG_M_IDX, 4'h4, `OAG_M_IND, 4'h4};
    op_dst_default_working_register <= 1'b0;
    go;
    chk("idx ea", {src_ea_q, dst_ea_q, dmem_wr_q},
        {16'h1244, 16'h0010, 1'b1});
    {op_src_mode, op_src_ptr, op_dst_mode, op_dst_ptr} <= {`OAG_M_IND, 4'h4, `OAG_M_IDX, 4'h3};
    go;
    chk("shared ofs", {src_ea_q, dst_ea_q}, {16'h0010, 16'h1244});
    {op_dst_default_working_register, op_is_move, op_src_ptr} <= {1'b1, 1'b0, 4'h3};
  endtask
  task s_table;
    wr(`OAG_ADDR_TBLPG, 16'h0081);
    rd(`OAG_ADDR_TBLPG, 16'h0081);
    setw(4'h3, 16'h4567);
    w = word_at(24'h814567);
    {op_src_mode, op_table} <= {`OAG_M_IND, 1'b1};
    go;
    chk("tbl addr", {pmem_addr_q, pmem_cfg_q}, {24'h814567, 1'b1});
    pd_wait;
    chk("tbl low", {n[3:0], pdata_q}, {4'h2, w[15:0]});
    op_table_hi <= 1'b1;
    go;
    pd_wait;
    chk("tbl high", pdata_q, {8'h00, w[23:16]});
    {op_table_hi, op_byte} <= 2'b01;
    go;
    pd_wait;
    chk("tbl byte", pdata_q, {8'h00, w[15:8]});
    wr(`OAG_ADDR_TBLPG, 16'h0001);
    {op_table, op_byte} <= 2'b10;
    go;
    chk("user page", {pmem_addr_q, pmem_cfg_q}, {24'h014567, 1'b0});
    pd_wait;
    op_table_wr <= 1'b1;
    go;
    chk("tbl write", {pmem_wr_q, pmem_rd_q, busy_q}, 3'b100);
    {op_table, op_table_wr} <= 2'b00;
  endtask
  task s_vis;
    wr(`OAG_ADDR_CORECTL, 16'h0004);
    wr(`OAG_ADDR_VISPG, 16'h0003);
    setw(4'h5, 16'h8123);
    w = word_at(24'h018123);
    op_src_ptr <= 4'h5;
    go;
    chk("vis addr", {pmem_rd_q, pmem_addr_q, pmem_cfg_q},
        {1'b1, 24'h018123, 1'b0});
    pd_wait;
    chk("vis data", {n[3:0], pdata_q}, {4'h3, w[15:0]});
    wr(`OAG_ADDR_CORECTL, 16'h0000);
    go;
    chk("vis off", {pmem_rd_q, dmem_rd_q}, 2'b01);
  endtask
  task s_prot;
    wr(`OAG_ADDR_PROT, 16'h0003);
    setw(4'h6, 16'h0850);
    setw(4'h7, 16'h0950);
    for (i = 0; i < 2; i = i + 1) begin
      {op_src_ptr, exec_in_secure, exec_in_boot} <= {4'h6 + i[3:0], 2'b10 >> i};
      go;
      chk("fault", {prot_fault_q, dmem_rd_q}, 2'b10);
      {exec_in_secure, exec_in_boot} <= 2'b01 << i;
      go;
      chk("allowed", {prot_fault_q, dmem_rd_q}, 2'b01);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    {mclk, reg_wr, reg_rd, op_valid, op_is_move, res_we, op_table, op_table_hi, op_table_wr,
     op_byte, exec_in_boot, exec_in_secure, res_pair, reg_addr, op_src_ptr, op_dst_ptr,
     op_ofs_reg, op_base_reg, res_idx, op_src_mode, op_dst_mode, op_lit_sel, op_step,
     reg_wdata, op_lit, res_data, res_data_hi} = 0;
    {sys_rst, ce, op_dst_default_working_register} = 3'b111;
    miscompares = 0;
    n_compared = 0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    s_regs;
    s_file;
    s_lits;
    s_ind;
    s_move;
    s_table;
    s_vis;
    s_prot;
    stop_test;
  end
endmodule
